// [rtl/req_decode_pkg.sv]
// Shared constants and types for the pipelined request decoder
package req_decode_pkg;

    // ****************************************
    // Command codes (four-bit command field)
    // ****************************************
    localparam logic [3:0] CMD_READ       = 4'h0;
    localparam logic [3:0] CMD_READ_HP    = 4'h1;
    localparam logic [3:0] CMD_WRITE      = 4'h4;
    localparam logic [3:0] CMD_WRITE_HP   = 4'h5;
    localparam logic [3:0] CMD_LREAD      = 4'h8;
    localparam logic [3:0] CMD_LREAD_HP   = 4'h9;
    localparam logic [3:0] CMD_FLUSH      = 4'hA;
    localparam logic [3:0] CMD_FENCE      = 4'hC;
    localparam logic [3:0] CMD_DUAL_ADDR  = 4'hD;

    // ****************************************
    // Request field layout and sizes
    // ****************************************
    localparam int         LEN_W          = 3;
    localparam int         UNITS_W        = 6;
    localparam int         UNIT_BYTES     = 8;
    localparam logic [5:0] LONG_MULT      = 6'h04;
    localparam logic [5:0] FLUSH_UNITS    = 6'h01;
    localparam int         FIFO_DEPTH     = 4;
    localparam int         ADDR_HI_W      = 61;

    // Command class handed to the read and write queues
    typedef enum logic [1:0] {
        CLS_READ  = 2'h0,
        CLS_WRITE = 2'h1,
        CLS_FLUSH = 2'h2,
        CLS_FENCE = 2'h3
    } cmd_class_t;

    // Request phase tracker, one-hot
    typedef enum logic [1:0] {
        ST_FIRST   = 2'b01,
        ST_UPPER   = 2'b10
    } phase_t;

    // Entry width: class, hp, push, slot, units, address, length
    localparam int ENTRY_W = 2 + 1 + 1 + 1 + UNITS_W + ADDR_HI_W + LEN_W;

endpackage : req_decode_pkg

// [rtl/req_decoder.sv]
// Pipelined request decoder with its output FIFO
// Overview of operation
// - Three low request bits give length in 8-byte units, 000 one, 111 eight.
// - Command comes on the command lines, or inside a sideband type 2 command.
// - Command 0000 reads length plus one consecutive 8-byte units.
// - Command 0001 is a read in the high-priority stream, ordered among its own.
// - Command 0100 writes length plus one units under byte enables; may pass reads.
// - Command 0101 is a high-priority write ordered only against its own kind.
// - Commands 1000 and 1001 move four times length plus one units.
// - Command 1010 drains earlier low-priority writes, returns one unit, ignores address.
// - Command 1100 is a fence in the low-priority stream using no slot.
// - 64-bit address takes two clocks: low address with 1101, then high and command.
// - Over the sideband port the two-clock address command is treated as reserved.
// - No ordering against processor or other-bus traffic; locks are not honoured.
// - Reads and writes go to main memory without cache snooping.
// - A flush forces all earlier low-priority writes into memory.
// - Conventional and pipelined streams need no mutual order, each keeps its own.
// - Conventional transactions, fast writes included, follow conventional ordering.
// - High and low priority streams carry no mutual order.
// - Addresses align to 8 bytes and lengths are whole 8-byte multiples.
// - Read data returns in request order within a stream.
// - A low-priority read pushes earlier low-priority writes ahead of it.
`timescale 1ns/10ps

// ****************************************
// Small FIFO between decoder and queues
// ****************************************
module req_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys_i,
    input  wire logic             reset_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] count_reg;
    wire              do_push;
    wire              do_pop;

    // Honest full and empty from the occupancy count
    assign in_ready_o  = (count_reg != CNT_W'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign out_data_o  = mem_reg[rd_ptr_reg];
    assign do_push     = in_valid_i && in_ready_o;
    assign do_pop      = out_valid_o && out_ready_i;

    // Pointer wrap, depth need not be a power of two
    function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
        bump = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
    endfunction : bump

    // Storage write
    always_ff @(posedge clk_sys_i) begin
        if (do_push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    // Pointers and count
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (do_push) wr_ptr_reg <= bump(wr_ptr_reg);
            if (do_pop) rd_ptr_reg <= bump(rd_ptr_reg);
            count_reg <= count_reg + CNT_W'(do_push) - CNT_W'(do_pop);
        end
    end

    a_fifo_bound : assert property (@(posedge clk_sys_i) disable iff (reset_i)
        count_reg <= CNT_W'(DEPTH))
        else $error("fifo count above depth");

endmodule : req_fifo

// ****************************************
// Request decoder top
// ****************************************
module req_decoder #(
    parameter int DEPTH = req_decode_pkg::FIFO_DEPTH
) (
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    input  wire logic        req_valid_i,
    output logic             req_ready_o,
    input  wire logic [31:0] req_addr_i,
    input  wire logic [3:0]  req_cmd_i,
    input  wire logic        sideband_mode_i,
    output logic             out_valid_o,
    input  wire logic        out_ready_i,
    output logic [1:0]       out_class_o,
    output logic             out_high_prio_o,
    output logic             out_push_lp_writes_o,
    output logic             out_slot_used_o,
    output logic [5:0]       out_units_o,
    output logic [63:0]      out_addr_o,
    output logic [2:0]       out_length_field_o,
    output logic             protocol_error_o
);
    // ****************************************
    // Local state and decode nets
    // ****************************************
    req_decode_pkg::phase_t               phase_reg;
    req_decode_pkg::phase_t               phase_next;
    logic [31:0]                          low_addr_reg;    // First clock of a wide request
    logic [31:0]                          low_addr_next;
    logic                                 error_reg;
    req_decode_pkg::cmd_class_t           cls_in;
    logic                                 hp_in;
    logic                                 push_in;
    logic                                 slot_in;
    logic [req_decode_pkg::UNITS_W-1:0]   units_in;
    logic [req_decode_pkg::LEN_W-1:0]     req_len;
    logic [req_decode_pkg::LEN_W-1:0]     len_in;
    logic [req_decode_pkg::ADDR_HI_W-1:0] addr_base;
    logic [req_decode_pkg::ADDR_HI_W-1:0] addr_hi_in;
    logic [req_decode_pkg::ADDR_HI_W-1:0] addr_hi_out;
    logic [req_decode_pkg::ENTRY_W-1:0]   entry_in;
    logic [req_decode_pkg::ENTRY_W-1:0]   entry_out;
    wire                                  take;
    wire                                  in_upper;
    wire                                  is_dual;
    wire                                  dual_start;
    wire                                  cmd_ok;
    wire                                  bad_cmd;
    wire                                  no_addr;
    wire                                  fifo_push;
    wire                                  fifo_in_ready;

    // Single clock domain for every check in this module
    default clocking cb_sys @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);

    // ****************************************
    // Command decode functions
    // ****************************************

    function automatic logic cmd_known(input logic [3:0] cmd);
        cmd_known = (cmd == req_decode_pkg::CMD_READ)     ||
                    (cmd == req_decode_pkg::CMD_READ_HP)  ||
                    (cmd == req_decode_pkg::CMD_WRITE)    ||
                    (cmd == req_decode_pkg::CMD_WRITE_HP) ||
                    (cmd == req_decode_pkg::CMD_LREAD)    ||
                    (cmd == req_decode_pkg::CMD_LREAD_HP) ||
                    (cmd == req_decode_pkg::CMD_FLUSH)    ||
                    (cmd == req_decode_pkg::CMD_FENCE);
    endfunction : cmd_known

    // writes own class
    // Flush and fence get classes of their own so queues can order around them
    function automatic req_decode_pkg::cmd_class_t class_of(input logic [3:0] cmd);
        if (cmd == req_decode_pkg::CMD_FLUSH) begin
            class_of = req_decode_pkg::CLS_FLUSH;
        end else if (cmd == req_decode_pkg::CMD_FENCE) begin
            class_of = req_decode_pkg::CLS_FENCE;
        end else if ((cmd == req_decode_pkg::CMD_WRITE) ||
                     (cmd == req_decode_pkg::CMD_WRITE_HP)) begin
            class_of = req_decode_pkg::CLS_WRITE;
        end else begin
            class_of = req_decode_pkg::CLS_READ;
        end
    endfunction : class_of

    // separate stream flag
    // The flag splits the streams; downstream queues may interleave them freely
    function automatic logic is_high(input logic [3:0] cmd);
        is_high = (cmd == req_decode_pkg::CMD_READ_HP)  ||
                  (cmd == req_decode_pkg::CMD_WRITE_HP) ||
                  (cmd == req_decode_pkg::CMD_LREAD_HP);
    endfunction : is_high

    function automatic logic pushes_writes(input logic [3:0] cmd);
        pushes_writes = (cmd == req_decode_pkg::CMD_READ)  ||
                        (cmd == req_decode_pkg::CMD_LREAD) ||
                        (cmd == req_decode_pkg::CMD_FLUSH);
    endfunction : pushes_writes

    function automatic logic [req_decode_pkg::UNITS_W-1:0] unit_count(
        input logic [3:0]                       cmd,
        input logic [req_decode_pkg::LEN_W-1:0] len
    );
        logic [req_decode_pkg::UNITS_W-1:0] base;
        base = {3'b000, len} + 6'h01;
        if (cmd == req_decode_pkg::CMD_FLUSH) begin
            unit_count = req_decode_pkg::FLUSH_UNITS;
        end else if (cmd == req_decode_pkg::CMD_FENCE) begin
            unit_count = '0;                             // Fence moves no data
        end else if ((cmd == req_decode_pkg::CMD_LREAD) ||
                     (cmd == req_decode_pkg::CMD_LREAD_HP)) begin
            unit_count = base * req_decode_pkg::LONG_MULT;
        end else begin
            unit_count = base;
        end
    endfunction : unit_count

    // ****************************************
    // Request acceptance and phase decode
    // ****************************************

    // conventional traffic bypasses
    // Only pipelined requests arrive here, so conventional cycles never wait on us
    assign req_ready_o = fifo_in_ready;
    assign take        = req_valid_i && req_ready_o;
    assign in_upper    = (phase_reg == req_decode_pkg::ST_UPPER);
    assign is_dual     = (req_cmd_i == req_decode_pkg::CMD_DUAL_ADDR);

    assign dual_start  = take && !in_upper && is_dual && !sideband_mode_i;

    // reserved code refused
    // A second wide-address code in the upper clock is refused as well
    assign cmd_ok      = cmd_known(req_cmd_i);
    assign bad_cmd     = take && !cmd_ok && !dual_start;
    assign fifo_push   = take && cmd_ok;

    // address aligned to units
    // Low three address bits carry length, so the address is rebuilt from bit 3 up
    assign req_len     = in_upper ? low_addr_reg[2:0] : req_addr_i[2:0];
    assign addr_base   = in_upper ? {req_addr_i, low_addr_reg[31:3]}
                                  : {32'h0000_0000, req_addr_i[31:3]};

    // flush ignores address
    // Zeroing keeps stale bits of meaningless fields out of the queues
    assign no_addr     = (req_cmd_i == req_decode_pkg::CMD_FLUSH) ||
                         (req_cmd_i == req_decode_pkg::CMD_FENCE);
    assign addr_hi_in  = no_addr ? '0 : addr_base;
    assign len_in      = no_addr ? '0 : req_len;

    assign slot_in     = (req_cmd_i != req_decode_pkg::CMD_FENCE);
    assign cls_in      = class_of(req_cmd_i);
    assign hp_in       = is_high(req_cmd_i);
    assign push_in     = pushes_writes(req_cmd_i);
    assign units_in    = unit_count(req_cmd_i, req_len);

    // no snoop request
    // Entries carry no coherency or lock field; memory is reached directly
    assign entry_in    = {cls_in, hp_in, push_in, slot_in, units_in, addr_hi_in, len_in};

    // ****************************************
    // Phase tracker and error flag
    // ****************************************

    // second clock completes request
    // Any accepted request in the upper clock ends the pair, good or refused
    always_comb begin
        phase_next    = phase_reg;
        low_addr_next = low_addr_reg;
        case (phase_reg)
            req_decode_pkg::ST_FIRST: begin
                if (dual_start) begin
                    phase_next    = req_decode_pkg::ST_UPPER;
                    low_addr_next = req_addr_i;
                end
            end
            req_decode_pkg::ST_UPPER: begin
                if (take) begin
                    phase_next = req_decode_pkg::ST_FIRST;
                end
            end
            default: begin
                phase_next = req_decode_pkg::ST_FIRST;
            end
        endcase
    end

    // State registers, synchronous reset
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            phase_reg    <= req_decode_pkg::ST_FIRST;
            low_addr_reg <= '0;
            error_reg    <= 1'b0;
        end else begin
            phase_reg    <= phase_next;
            low_addr_reg <= low_addr_next;
            error_reg    <= bad_cmd;
        end
    end

    assign protocol_error_o = error_reg;   // One-cycle pulse per refused request

    // ****************************************
    // Entry FIFO and output unpacking
    // ****************************************

    // in-order hand-over
    // Queue order is arrival order, which keeps each stream's replies in order
    req_fifo #(
        .WIDTH (req_decode_pkg::ENTRY_W),
        .DEPTH (DEPTH)
    ) entry_fifo (
        .clk_sys_i   (clk_sys_i),
        .reset_i     (reset_i),
        .in_valid_i  (fifo_push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (entry_in),
        .out_valid_o (out_valid_o),
        .out_ready_i (out_ready_i),
        .out_data_o  (entry_out)
    );

    assign {out_class_o, out_high_prio_o, out_push_lp_writes_o, out_slot_used_o,
            out_units_o, addr_hi_out, out_length_field_o} = entry_out;
    assign out_addr_o = {addr_hi_out, 3'b000};

    // ****************************************
    // Checks and coverage
    // ****************************************

    a_reserved_flag : assert property (bad_cmd |=> protocol_error_o)
        else $error("reserved code did not raise the error pulse");
    a_sideband_wide : assert property ((take && is_dual && sideband_mode_i) |=> protocol_error_o)
        else $error("wide address code accepted over sideband port");
    a_wide_enter : assert property (dual_start |=> in_upper)
        else $error("wide address first clock did not arm upper phase");
    a_wide_leave : assert property ((in_upper && take) |=> !in_upper)
        else $error("upper phase did not end after second clock");
    a_fence_slot : assert property ((out_valid_o && out_class_o == req_decode_pkg::CLS_FENCE)
        |-> !out_slot_used_o) else $error("fence entry claims a pipeline slot");
    a_flush_unit : assert property ((out_valid_o && out_class_o == req_decode_pkg::CLS_FLUSH)
        |-> (out_units_o == req_decode_pkg::FLUSH_UNITS) && out_push_lp_writes_o)
        else $error("flush entry has wrong count or no write push");
    a_lp_read_push : assert property ((out_valid_o && out_class_o == req_decode_pkg::CLS_READ
        && !out_high_prio_o) |-> out_push_lp_writes_o) else $error("low read lacks write push");
    a_write_units : assert property ((out_valid_o && out_class_o == req_decode_pkg::CLS_WRITE)
        |-> (out_units_o != '0) && (out_units_o <= 6'h08)) else $error("write count out of range");

    // Main scenarios worth seeing
    c_wide_pair : cover property (in_upper && take);
    c_refused : cover property (bad_cmd);
    c_fifo_full : cover property (!req_ready_o);
    c_long_read : cover property (out_valid_o && out_units_o == 6'h20);

endmodule : req_decoder

// [verif/master_model.sv]
// Master model that issues pipelined requests
`timescale 1ns/10ps
module master_model (
    input  wire logic        clk_sys_i,
    input  wire logic        ready_i,
    output logic             valid_o,
    output logic [31:0]      addr_o,
    output logic [3:0]       cmd_o
);
    initial begin
        valid_o = 1'b0;
        addr_o = 32'h0000_0000;
        cmd_o = 4'h0;
    end
    task automatic send(input logic [31:0] a, input logic [3:0] c);
        @(negedge clk_sys_i);
        valid_o = 1'b1;
        addr_o = a;
        cmd_o = c;
        @(posedge clk_sys_i);
        while (ready_i !== 1'b1) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        valid_o = 1'b0;
        addr_o = ~a; // Stale bus shows junk
        cmd_o = ~c;
    endtask : send
endmodule : master_model

// [verif/tb.sv]
// Self-checking bench for the request decoder
`timescale 1ns/10ps
module tb;
    logic clk_sys_i, reset_i, req_valid_i, req_ready_o, sideband_mode_i, out_valid_o;
    logic out_ready_i, out_high_prio_o, out_push_lp_writes_o, out_slot_used_o, protocol_error_o;
    logic [31:0] req_addr_i;
    logic [3:0]  req_cmd_i;
    logic [1:0]  out_class_o;
    logic [5:0]  out_units_o;
    logic [63:0] out_addr_o;
    logic [2:0]  out_length_field_o;
    int n_errors = 0, n_tests = 0, cyc = 0;
    logic [3:0] cmdt [8] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hC};
    logic [3:0] rsv [7] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'hB, 4'hE, 4'hF};
    master_model mm (.clk_sys_i, .ready_i(req_ready_o), .valid_o(req_valid_i),
                     .addr_o(req_addr_i), .cmd_o(req_cmd_i));
    req_decoder dut (.clk_sys_i, .reset_i, .req_valid_i, .req_ready_o, .req_addr_i, .req_cmd_i,
        .sideband_mode_i, .out_valid_o, .out_ready_i, .out_class_o, .out_high_prio_o,
        .out_push_lp_writes_o, .out_slot_used_o, .out_units_o, .out_addr_o, .out_length_field_o,
        .protocol_error_o);
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    // Guard against a hang
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc > 5000) begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic chk(input string w, input logic [63:0] s, input logic [63:0] e);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", w, e, s);
        end
    endtask : chk
    task automatic pop(input logic [1:0] c, input logic h, input logic [5:0] u, input logic [63:0] a);
        int k = 0;
        @(negedge clk_sys_i);
        out_ready_i = 1'b1;
        while (out_valid_o !== 1'b1 && k < 60) begin
            @(negedge clk_sys_i);
            k++;
        end
        chk("valid", out_valid_o, 1);
        chk("class", out_class_o, c);
        chk("prio", out_high_prio_o, h);
        chk("slot", out_slot_used_o, c != 2'h3);
        if (c != 2'h3) chk("units", out_units_o, u);
        if (c < 2'h2) chk("addr", out_addr_o, {a[63:3], 3'b000});
        if (c < 2'h2) chk("len", out_length_field_o, a[2:0]);
        chk("push", out_push_lp_writes_o, (c == 2'h0 && !h) || c == 2'h2);
        @(negedge clk_sys_i);
        out_ready_i = 1'b0;
    endtask : pop
    task automatic bad(input logic [3:0] c);
        logic e = 1'b0;
        mm.send(32'h0000_0040, c);
        e = (protocol_error_o === 1'b1); // Error pulse stands one cycle only
        repeat (8) @(negedge clk_sys_i) e |= (protocol_error_o === 1'b1);
        chk("err", e, 1);
        chk("novalid", out_valid_o, 0);
    endtask : bad
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up
    initial begin
        logic [3:0] c;
        logic [31:0] a;
        reset_i = 1'b1;
        out_ready_i = 1'b0;
        sideband_mode_i = 1'b0;
        repeat (8) @(negedge clk_sys_i);
        reset_i = 1'b0;
        // flush issued ahead of any sync event
        // Every single-clock command code at both length extremes
        foreach (cmdt[i]) for (int l = 0; l < 8; l += 7) begin
            c = cmdt[i];
            a = 32'h0001_2340 | l;
            mm.send(a, c);
            pop(c == 4'hA ? 2'h2 : c == 4'hC ? 2'h3 : {1'b0, c[2]}, c[0] & ~c[3] | c == 4'h9,
                c == 4'hA ? 6'h01 : c[3] ? 6'((l + 1) * 4) : 6'(l + 1), {32'h0, a});
        end
        mm.send(32'h8765_4325, 4'hD);
        mm.send(32'h0000_00AB, 4'h4);
        pop(2'h1, 1'b0, 6'h06, 64'h0000_00AB_8765_4325);
        for (int i = 0; i < 4; i++) mm.send(32'h0000_1000 + 32'(i * 8), 4'h0);
        for (int i = 0; i < 4; i++) pop(2'h0, 1'b0, 6'h01, 64'h1000 + 64'(i * 8));
        foreach (rsv[i]) bad(rsv[i]);
        mm.send(32'h0000_0040, 4'hD);
        bad(4'h2);
        sideband_mode_i = 1'b1;
        bad(4'hD);
        wrap_up();
    end
endmodule : tb
